// ===== src/snvm_cfg.svh
// constants of the serial nonvolatile memory link and its two ends
`ifndef SNVM_CFG_SVH
`define SNVM_CFG_SVH

// memory geometry
`define SNVM_AW 13
`define SNVM_DEPTH 8192
`define SNVM_AHI_W 5

// command opcodes
`define SNVM_OP_WRITE_ENABLE_CMD 8'h06
`define SNVM_OP_READ 8'h03
`define SNVM_OP_WRITE 8'h02

// block protect bases
`define SNVM_QTR_BASE 13'h1800
`define SNVM_HALF_BASE 13'h1000

// framing
`define SNVM_BIT_LAST 3'h7
`define SNVM_IDX_DATA 2'h3
`define SNVM_PIN_IDLE 4'h9
`define SNVM_FIFO_DEPTH 2

// timing, core clock 25 MHz
`define SNVM_CLK_NS 40
`define SNVM_SCK_HALF_NS 480
`define SNVM_SCK_HALF (`SNVM_SCK_HALF_NS / `SNVM_CLK_NS)

`endif

// ===== src/snvm_pkg.sv
// types shared by both ends of the serial nonvolatile memory link
package snvm_pkg;

    typedef enum logic [2:0] {
        D_OPC = 3'b000,
        D_AHI = 3'b001,
        D_ALO = 3'b010,
        D_WDATA = 3'b011,
        D_RDATA = 3'b100,
        D_SKIP = 3'b101
    } snvm_dev_st_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_BYTE = 3'b010,
        H_LO = 3'b011,
        H_HI = 3'b100,
        H_DESEL = 3'b101
    } snvm_host_st_e;

    typedef enum logic [1:0] {
        CMD_WRITE_ENABLE_CMD = 2'b00,
        CMD_READ = 2'b01,
        CMD_WRITE = 2'b10
    } snvm_cmd_e;

endpackage

// ===== src/snvm_link_if.sv
// serial link between master and memory device
`timescale 1ns/1ps
interface snvm_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic so_out;
    logic so_oe;
    logic so;

    // undriven serial output floats, seen high through a pull-up
    assign so = so_oe ? so_out : 1'b1;

    modport device(input cs_n, input sck, input si, input hold_n, output so_out, output so_oe);
    modport host(output cs_n, output sck, output si, output hold_n, input so);
endinterface

// ===== src/snvm_device.sv
// memory device end of the serial link: command decode, array, hold
`timescale 1ns/1ps
// Functional notes
// - master sends write enable in own frame
// - write address two bytes, low 13 used
// - each write byte stored, address advances
// - address wraps from top to zero
// - write data arrives msb first
// - chip select rise ends write
// - byte committed right after eighth clock
// - sequential write has no length limit
// - read address two bytes, low 13 used
// - addressed byte shifted out next eight clocks
// - serial input ignored during read data
// - read advances address, continues while clocked
// - read data leaves msb first
// - chip select rise ends read
// - hold low with clock low pauses
// - hold high with clock low resumes
// - hold changes only with clock low
// - opcodes 06, 03, 02; one per frame
// - write latch clears after write frame
// - block protect bits select protected range
// - sample on rise, drive on fall, bytes
`include "snvm_cfg.svh"
module snvm_device
    import snvm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // serial link
    snvm_link_if.device link,
    // protection setting
    input wire logic block_protect_hi,
    input wire logic block_protect_lo,
    // status
    output logic write_enable_latch_flag,
    output logic paused
);

    localparam int NIN = 4;
    localparam logic [NIN-1:0] PIN_IDLE = `SNVM_PIN_IDLE;

    logic [NIN-1:0] pin_raw;
    wire [NIN-1:0] flt;
    logic [NIN-1:0] flt_q_r;
    logic cs_n_f;
    logic sck_f;
    logic si_f;
    logic hold_n_f;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic act_rise;
    logic act_fall;
    logic paused_r;
    snvm_dev_st_e state_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] byte_in;
    logic byte_done;
    logic rd_r;
    logic wr_frame_r;
    logic wel_r;
    logic [`SNVM_AW-1:0] addr_r;
    logic [`SNVM_AW-1:0] addr_nxt;
    logic [`SNVM_AW-1:0] start_addr;
    logic [`SNVM_AHI_W-1:0] ahi_r;
    logic [7:0] rd_sh_r;
    logic so_r;
    logic oe_r;
    logic store_en;
    logic [7:0] mem_r [0:`SNVM_DEPTH-1];

    // protected range decode from the two block protect bits
    function automatic logic is_protected(input logic [`SNVM_AW-1:0] a,
                                          input logic [1:0] bp);
        logic p;
        p = 1'b0;
        unique case (bp)
            2'b00: p = 1'b0;
            2'b01: p = (a >= `SNVM_QTR_BASE);
            2'b10: p = (a >= `SNVM_HALF_BASE);
            2'b11: p = 1'b1;
        endcase
        return p;
    endfunction

    assign pin_raw = {link.hold_n, link.si, link.sck, link.cs_n};

    // three-stage sampling; a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            logic a_r;
            logic b_r;
            logic c_r;
            logic f_r;
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    a_r <= PIN_IDLE[gi];
                    b_r <= PIN_IDLE[gi];
                    c_r <= PIN_IDLE[gi];
                    f_r <= PIN_IDLE[gi];
                end else begin
                    a_r <= pin_raw[gi];
                    b_r <= a_r;
                    c_r <= b_r;
                    if (b_r == c_r) begin
                        f_r <= c_r;
                    end
                end
            end
            assign flt[gi] = f_r;
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flt_q_r <= PIN_IDLE;
        end else begin
            flt_q_r <= flt;
        end
    end

    assign cs_n_f = flt[0];
    assign sck_f = flt[1];
    assign si_f = flt[2];
    assign hold_n_f = flt[3];
    assign sck_rise = sck_f & ~flt_q_r[1];
    assign sck_fall = ~sck_f & flt_q_r[1];
    assign cs_rise = cs_n_f & ~flt_q_r[0];

    // hold is only looked at while the clock is low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            paused_r <= 1'b0;
        end else if (cs_n_f) begin
            paused_r <= 1'b0;
        end else if (!sck_f) begin
            paused_r <= ~hold_n_f;
        end
    end

    // clock edges while paused are dropped
    assign act_rise = sck_rise & ~paused_r & ~cs_n_f;
    assign act_fall = sck_fall & ~paused_r & ~cs_n_f;
    assign byte_in = {sh_r[6:0], si_f};
    assign byte_done = act_rise && (bit_r == `SNVM_BIT_LAST);
    // the shifter has moved on by the low byte, so the high bits are kept aside
    assign start_addr = {ahi_r, byte_in};
    assign addr_nxt = addr_r + `SNVM_AW'(1);

    // bit position and input shifter; a partial byte dies with the frame
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bit_r <= 3'h0;
            sh_r <= 8'h00;
        end else if (cs_n_f) begin
            bit_r <= 3'h0;
        end else if (act_rise) begin
            bit_r <= bit_r + 3'h1;
            sh_r <= byte_in;
        end
    end

    // command sequencing; deselect returns to opcode fetch
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= D_OPC;
            rd_r <= 1'b0;
        end else if (cs_n_f) begin
            state_r <= D_OPC;
        end else if (byte_done) begin
            unique case (state_r)
                D_OPC: begin
                    unique case (byte_in)
                        `SNVM_OP_READ: begin
                            state_r <= D_AHI;
                            rd_r <= 1'b1;
                        end
                        `SNVM_OP_WRITE: begin
                            state_r <= D_AHI;
                            rd_r <= 1'b0;
                        end
                        default: state_r <= D_SKIP;
                    endcase
                end
                D_AHI: state_r <= D_ALO;
                D_ALO: state_r <= rd_r ? D_RDATA : D_WDATA;
                D_WDATA: state_r <= D_WDATA;
                D_RDATA: state_r <= D_RDATA;
                D_SKIP: state_r <= D_SKIP;
                default: state_r <= D_SKIP;
            endcase
        end
    end

    // upper three address bits are dropped on entry
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= '0;
            ahi_r <= '0;
        end else if (byte_done) begin
            if (state_r == D_AHI) begin
                ahi_r <= byte_in[`SNVM_AHI_W-1:0];
            end else if (state_r == D_ALO) begin
                addr_r <= start_addr;
            end else if (state_r == D_WDATA || state_r == D_RDATA) begin
                addr_r <= addr_nxt;
            end
        end
    end

    // write enable latch, set by its own frame, cleared after a write frame
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wel_r <= 1'b0;
            wr_frame_r <= 1'b0;
        end else if (cs_rise) begin
            wr_frame_r <= 1'b0;
            if (wr_frame_r) begin
                wel_r <= 1'b0;
            end
        end else if (byte_done && state_r == D_OPC) begin
            if (byte_in == `SNVM_OP_WRITE_ENABLE_CMD) begin
                wel_r <= 1'b1;
            end
            wr_frame_r <= (byte_in == `SNVM_OP_WRITE);
        end
    end

    assign store_en = byte_done && state_r == D_WDATA && wel_r &&
                      !is_protected(addr_r, {block_protect_hi, block_protect_lo});

    // array written at once on the eighth rising edge, no page buffer
    always_ff @(posedge core_clk) begin
        if (store_en) begin
            mem_r[addr_r] <= byte_in;
        end
    end

    // read shifter: loaded at byte end, shifted on each falling edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_sh_r <= 8'h00;
            so_r <= 1'b0;
        end else if (byte_done && state_r == D_ALO && rd_r) begin
            rd_sh_r <= mem_r[start_addr];
        end else if (byte_done && state_r == D_RDATA) begin
            rd_sh_r <= mem_r[addr_nxt];
        end else if (act_fall && state_r == D_RDATA) begin
            so_r <= rd_sh_r[7];
            rd_sh_r <= {rd_sh_r[6:0], 1'b0};
        end
    end

    // output enabled from the first data fall until deselect
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            oe_r <= 1'b0;
        end else if (cs_n_f) begin
            oe_r <= 1'b0;
        end else if (act_fall && state_r == D_RDATA) begin
            oe_r <= 1'b1;
        end
    end

    assign link.so_out = so_r;
    assign link.so_oe = oe_r & ~paused_r;
    assign write_enable_latch_flag = wel_r;
    assign paused = paused_r;

endmodule

// ===== src/snvm_host.sv
// master end of the serial link: framing, clock divider, read buffer
`timescale 1ns/1ps
`include "snvm_cfg.svh"
module snvm_host
    import snvm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // serial link
    snvm_link_if.host link,
    // command request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire snvm_cmd_e cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_len,
    // write data stream
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // read data stream
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    // pause and status
    input wire logic pause_req,
    output logic busy
);

    localparam logic [7:0] HALF = 8'(`SNVM_SCK_HALF);

    snvm_host_st_e st_r;
    snvm_cmd_e op_r;
    logic [15:0] addr_r;
    logic [15:0] left_r;
    logic [7:0] div_r;
    logic div_end;
    logic [2:0] bit_r;
    logic [1:0] idx_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic cs_n_r;
    logic sck_r;
    logic si_r;
    logic hold_n_r;
    logic so_a_r;
    logic so_b_r;
    logic so_c_r;
    logic so_f_r;
    logic [7:0] fifo_r [0:`SNVM_FIFO_DEPTH-1];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;
    logic data_ph;
    logic take_wr;

    // serial output sampled in three stages; agreement of two and three counts
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            so_a_r <= 1'b1;
            so_b_r <= 1'b1;
            so_c_r <= 1'b1;
            so_f_r <= 1'b1;
        end else begin
            so_a_r <= link.so;
            so_b_r <= so_a_r;
            so_c_r <= so_b_r;
            if (so_b_r == so_c_r) begin
                so_f_r <= so_c_r;
            end
        end
    end

    assign div_end = (div_r == HALF - 8'h1);
    assign data_ph = (idx_r == `SNVM_IDX_DATA);
    assign take_wr = st_r == H_BYTE && hold_n_r && !pause_req && data_ph &&
                     op_r == CMD_WRITE && left_r != 16'h0 && wr_valid;
    assign push = st_r == H_HI && div_end && bit_r == `SNVM_BIT_LAST && data_ph &&
                  op_r == CMD_READ;
    assign pop = rd_valid && rd_ready;

    // frame sequencing; clock is stopped low whenever a byte cannot start
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= H_IDLE;
            op_r <= CMD_WRITE_ENABLE_CMD;
            addr_r <= 16'h0;
            left_r <= 16'h0;
            div_r <= 8'h0;
            bit_r <= 3'h0;
            idx_r <= 2'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
            si_r <= 1'b0;
            hold_n_r <= 1'b1;
        end else begin
            unique case (st_r)
                H_IDLE: begin
                    div_r <= 8'h0;
                    if (cmd_valid) begin
                        op_r <= cmd_op;
                        addr_r <= cmd_addr;
                        left_r <= cmd_len;
                        idx_r <= 2'h0;
                        cs_n_r <= 1'b0;
                        st_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    div_r <= div_end ? 8'h0 : div_r + 8'h1;
                    if (div_end) begin
                        st_r <= H_BYTE;
                    end
                end
                H_BYTE: begin
                    div_r <= 8'h0;
                    bit_r <= 3'h0;
                    // hold moves only here, with the clock low
                    if (pause_req || !hold_n_r) begin
                        hold_n_r <= ~pause_req;
                    end else if (idx_r == 2'h0) begin
                        tx_r <= (op_r == CMD_READ) ? `SNVM_OP_READ :
                                (op_r == CMD_WRITE) ? `SNVM_OP_WRITE : `SNVM_OP_WRITE_ENABLE_CMD;
                        st_r <= H_LO;
                    end else if (op_r == CMD_WRITE_ENABLE_CMD || (data_ph && left_r == 16'h0)) begin
                        cs_n_r <= 1'b1;
                        st_r <= H_DESEL;
                    end else if (idx_r == 2'h1) begin
                        tx_r <= addr_r[15:8];
                        st_r <= H_LO;
                    end else if (idx_r == 2'h2) begin
                        tx_r <= addr_r[7:0];
                        st_r <= H_LO;
                    end else if (take_wr) begin
                        tx_r <= wr_data;
                        st_r <= H_LO;
                    end else if (op_r == CMD_READ && cnt_r < 2'(`SNVM_FIFO_DEPTH)) begin
                        tx_r <= 8'h00;
                        st_r <= H_LO;
                    end
                end
                H_LO: begin
                    si_r <= tx_r[7];
                    div_r <= div_end ? 8'h0 : div_r + 8'h1;
                    if (div_end) begin
                        sck_r <= 1'b1;
                        rx_r <= {rx_r[6:0], so_f_r};
                        st_r <= H_HI;
                    end
                end
                H_HI: begin
                    div_r <= div_end ? 8'h0 : div_r + 8'h1;
                    if (div_end) begin
                        sck_r <= 1'b0;
                        tx_r <= {tx_r[6:0], 1'b0};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == `SNVM_BIT_LAST) begin
                            st_r <= H_BYTE;
                            if (data_ph) begin
                                left_r <= left_r - 16'h1;
                            end else begin
                                idx_r <= idx_r + 2'h1;
                            end
                        end else begin
                            st_r <= H_LO;
                        end
                    end
                end
                H_DESEL: begin
                    div_r <= div_end ? 8'h0 : div_r + 8'h1;
                    if (div_end) begin
                        st_r <= H_IDLE;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    // two-entry read buffer; a full buffer holds the next byte from starting
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            fifo_r[wp_r] <= rx_r;
        end
    end

    assign cmd_ready = (st_r == H_IDLE);
    assign wr_ready = take_wr;
    assign rd_valid = (cnt_r != 2'h0);
    assign rd_data = fifo_r[rp_r];
    assign busy = (st_r != H_IDLE);
    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.si = si_r;
    assign link.hold_n = hold_n_r;

endmodule

// ===== verification/snvm_link_asserts.sv
// protocol assertions on the serial memory link between host and device
`timescale 1ns/1ps
module snvm_link_asserts (
    // clock and reset
    input logic core_clk,
    input logic nrst,
    // link signals
    input logic cs_n,
    input logic sck,
    input logic si,
    input logic hold_n,
    input logic so_out,
    input logic so_oe,
    input logic so
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // device sees chip select late through its filter, so allow a few cycles
    a_so_idle_release: assert property (cs_n [*8] |-> !so_oe && so)
        else $error("serial output driven while deselected");
    a_hold_masks_so: assert property (!hold_n [*8] |-> !so_oe)
        else $error("serial output driven during pause");
    a_hold_sck_low: assert property ($changed(hold_n) |-> !sck)
        else $error("pause pin moved while serial clock high");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock high outside a frame");
    a_frame_setup: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("serial clock rose too soon after select");
    a_sck_high_len: assert property ($rose(sck) |-> sck [*8])
        else $error("serial clock high phase too short");
    a_si_stable_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    a_so_fall_only: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !sck)
        else $error("serial output changed while clock high");
    a_deselect_len: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("deselect gap too short");

    c_frame: cover property ($fell(cs_n));
    c_read_data: cover property ($rose(so_oe));
    c_pause: cover property ($fell(hold_n));
endmodule

// ===== verification/serial_nv_memory_access_tb.sv
// self-checking bench joining the host and device ends of the memory link
`timescale 1ns/1ps
`include "snvm_cfg.svh"
module serial_nv_memory_access_tb
    import snvm_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    snvm_cmd_e cmd_op = CMD_WRITE_ENABLE_CMD;
    logic [15:0] cmd_addr = 16'h0000;
    logic [15:0] cmd_len = 16'h0000;
    logic wr_valid = 1'b0;
    logic wr_ready;
    logic [7:0] wr_data = 8'h00;
    logic rd_valid;
    logic rd_ready = 1'b0;
    logic [7:0] rd_data;
    logic pause_req = 1'b0;
    logic busy;
    logic block_protect_hi = 1'b0;
    logic block_protect_lo = 1'b0;
    logic write_enable_latch_flag;
    logic paused;
    int n_errors = 0;
    int check_count = 0;
    logic [31:0] cap;
    int sck_cnt = 0;

    always #20 core_clk = ~core_clk;

    snvm_link_if snvm_link_if_inst ();

    snvm_host snvm_host_inst (.core_clk(core_clk), .nrst(nrst), .link(snvm_link_if_inst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .pause_req(pause_req),
        .busy(busy));

    snvm_device snvm_device_inst (.core_clk(core_clk), .nrst(nrst), .link(snvm_link_if_inst),
        .block_protect_hi(block_protect_hi), .block_protect_lo(block_protect_lo),
        .write_enable_latch_flag(write_enable_latch_flag), .paused(paused));

    snvm_link_asserts snvm_link_asserts_inst (.core_clk(core_clk), .nrst(nrst),
        .cs_n(snvm_link_if_inst.cs_n), .sck(snvm_link_if_inst.sck), .si(snvm_link_if_inst.si),
        .hold_n(snvm_link_if_inst.hold_n), .so_out(snvm_link_if_inst.so_out),
        .so_oe(snvm_link_if_inst.so_oe), .so(snvm_link_if_inst.so));

    // wire monitor: first 32 bits of each frame and its clock count
    always @(negedge snvm_link_if_inst.cs_n or posedge snvm_link_if_inst.sck) begin
        if (snvm_link_if_inst.sck) begin
            if (sck_cnt < 32) cap[31 - sck_cnt] = snvm_link_if_inst.si;
            sck_cnt = sck_cnt + 1;
        end else begin
            sck_cnt = 0;
        end
    end

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // a bounded wait that ran out ends the run as a failure
    task automatic wait_on(ref logic sig, input logic lvl);
        int i;
        for (i = 0; i < 9000 && sig !== lvl; i++) tick();
        if (i == 9000) begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic issue(snvm_cmd_e op, logic [15:0] a, logic [15:0] n);
        cmd_op = op;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        wait_on(cmd_ready, 1'b1);
        tick();
        cmd_valid = 1'b0;
    endtask

    task automatic write_enable_cmd();
        issue(CMD_WRITE_ENABLE_CMD, 16'h0000, 16'h0000);
        wait_on(busy, 1'b0);
        chk(sck_cnt, 8);
        chk(cap[31:24], `SNVM_OP_WRITE_ENABLE_CMD);
        chk(write_enable_latch_flag, 1'b1);
    endtask

    task automatic wr(logic [15:0] a, int n, logic [31:0] d);
        issue(CMD_WRITE, a, n[15:0]);
        for (int k = 0; k < n; k++) begin
            wr_data = d[31 - 8 * k -: 8];
            wr_valid = 1'b1;
            wait_on(wr_ready, 1'b1);
            tick();
        end
        wr_valid = 1'b0;
        wait_on(busy, 1'b0);
        chk(cap, {`SNVM_OP_WRITE, a, d[31:24]});
        chk(sck_cnt, 8 * (3 + n));
        chk(write_enable_latch_flag, 1'b0);
    endtask

    task automatic rd(logic [15:0] a, int n, logic [31:0] d, bit stall, bit pz);
        issue(CMD_READ, a, n[15:0]);
        if (pz) begin
            tick(650);
            pause_req = 1'b1;
            wait_on(paused, 1'b1);
            tick(200);
            chk(snvm_link_if_inst.cs_n, 1'b0);
            chk(snvm_link_if_inst.so, 1'b1);
            chk(snvm_link_if_inst.so_oe, 1'b0);
            pause_req = 1'b0;
            wait_on(paused, 1'b0);
        end
        // long stall lets the two-entry buffer fill and the host hold its clock
        if (stall) begin
            tick(1400);
            chk(rd_valid, 1'b1);
        end
        rd_ready = 1'b1;
        for (int k = 0; k < n; k++) begin
            wait_on(rd_valid, 1'b1);
            chk(rd_data, d[31 - 8 * k -: 8]);
            tick();
        end
        rd_ready = 1'b0;
        wait_on(busy, 1'b0);
        chk(cap[31:8], {`SNVM_OP_READ, a});
        chk(sck_cnt, 8 * (3 + n));
    endtask

    task automatic t_wrap_write();
        write_enable_cmd();
        wr(16'hfffe, 3, 32'ha53c8100);
    endtask

    task automatic t_read_stall();
        rd(16'h3ffe, 3, 32'ha53c8100, 1'b1, 1'b0);
    endtask

    task automatic t_no_latch();
        wr(16'h0000, 1, 32'h5a000000);
        rd(16'h0000, 1, 32'h81000000, 1'b0, 1'b0);
    endtask

    task automatic t_protect();
        write_enable_cmd();
        wr(16'h17ff, 2, 32'h77880000);
        write_enable_cmd();
        wr(16'h0fff, 2, 32'h44550000);
        {block_protect_hi, block_protect_lo} = 2'h1;
        write_enable_cmd();
        wr(16'h17ff, 2, 32'h11220000);
        rd(16'h17ff, 2, 32'h11880000, 1'b0, 1'b0);
        write_enable_cmd();
        wr(16'h1fff, 2, 32'hee5a0000);
        rd(16'h1fff, 2, 32'h3c5a0000, 1'b0, 1'b0);
        {block_protect_hi, block_protect_lo} = 2'h2;
        write_enable_cmd();
        wr(16'h0fff, 2, 32'h33660000);
        rd(16'h0fff, 2, 32'h33550000, 1'b0, 1'b0);
        {block_protect_hi, block_protect_lo} = 2'h3;
        write_enable_cmd();
        wr(16'h0fff, 1, 32'h99000000);
        rd(16'h0fff, 1, 32'h33000000, 1'b0, 1'b0);
        {block_protect_hi, block_protect_lo} = 2'h0;
    endtask

    task automatic t_pause();
        rd(16'h17ff, 2, 32'h11880000, 1'b0, 1'b1);
    endtask

    initial begin
        tick(8);
        nrst = 1'b1;
        chk(snvm_link_if_inst.cs_n, 1'b1);
        chk({cmd_ready, busy, write_enable_latch_flag, rd_valid}, 4'h8);
        t_wrap_write();
        t_read_stall();
        t_no_latch();
        t_protect();
        t_pause();
        test_done();
    end
endmodule
